/* File: verilog/ivc_ctrl.sv */
// Interrupt priority, vector base and fast interrupt block with Avalon-MM registers
`timescale 1ns/1ps
module ivc_ctrl import ivc_pkg::*; #(
  parameter logic [15:0]          VBA_RESET = 16'h0000,
  parameter logic [IVC_VEC_W-1:0] VEC_BASE  = 6'h10
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_n_i,
  // Avalon-MM slave
  input  wire logic [7:0]             avs_address_i,
  input  wire logic                   avs_read_i,
  input  wire logic                   avs_write_i,
  input  wire logic [31:0]            avs_writedata_i,
  input  wire logic [3:0]             avs_byteenable_i,
  output      logic [31:0]            avs_readdata_o,
  output      logic [1:0]             avs_response_o,
  output      logic                   avs_waitrequest_o,
  // Peripheral request lines, one per source
  input  wire logic [IVC_NUM_SRC-1:0] src_req_i,
  // Core side
  input  wire logic                   core_ack_i,
  output      ivc_core_req_t          core_req_o,
  output      logic                   irq_o
);

  // Register state of the block; event status and enable are held in ivc_events
  typedef struct packed {
    logic                  ack;
    logic [31:0]           rdata;
    logic [1:0]            resp;
    logic [15:0]           prio5;
    logic [15:0]           prio6;
    logic [15:0]           vector_base_address;
    logic [IVC_VEC_W-1:0]  fast_irq0_select;
    logic [15:0]           fast_irq0_target_low;
    logic [IVC_FHI_W-1:0]  fast_irq0_target_high;
    logic [IVC_VEC_W-1:0]  fim1;
    logic [15:0]           fival1;
    logic [IVC_FHI_W-1:0]  fivah1;
    ivc_core_req_t         core;
  } ivc_state_t;

  ivc_state_t                 st_reg;
  ivc_state_t                 st_next;
  ivc_win_t                   win;
  logic [2*IVC_NUM_SRC-1:0]   prio_all;
  logic [5:0]                 reg_idx;
  logic                       bus_req;
  logic                       bus_take;
  logic                       wr_take;
  logic [15:0]                wmask;
  logic [15:0]                wval;
  logic                       mapped;
  logic [IVC_NUM_EVT-1:0]     evt;
  logic [IVC_NUM_EVT-1:0]     evt_status;
  logic [IVC_NUM_EVT-1:0]     evt_enable;
  logic                       evt_en_wr;
  logic                       evt_clr_wr;

  // Merge a write into a stored halfword honouring byte lanes and reserved bits
  function automatic logic [15:0] merge16(input logic [15:0] old_val,
                                          input logic [15:0] new_val,
                                          input logic [15:0] lane_mask,
                                          input logic [15:0] keep_mask);
    merge16 = ((old_val & ~lane_mask) | (new_val & lane_mask)) & keep_mask;
  endfunction

  // Forms the 21-bit address of a jump-table entry for a vector number
  function automatic logic [IVC_ADDR_W-1:0] table_addr(input logic [15:0]          base,
                                                       input logic [IVC_VEC_W-1:0] vec);
    table_addr = {base[IVC_BASE_W-1:0], vec, 1'b0};
  endfunction

  // Register index and bus handshake
  assign reg_idx  = avs_address_i[7:2];
  assign bus_req  = avs_read_i | avs_write_i;
  assign bus_take = bus_req & st_reg.ack;
  assign wr_take  = avs_write_i & st_reg.ack;
  // One wait state: request held, answer at the second edge
  assign avs_waitrequest_o = bus_req & ~st_reg.ack;
  assign avs_readdata_o    = st_reg.rdata;
  assign avs_response_o    = st_reg.resp;

  // Byte lanes 0 and 1 carry the 16-bit registers; upper lanes are ignored
  assign wmask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign wval  = avs_writedata_i[15:0];

  // Packed priority fields, source i at bits 2i+1..2i
  // Bank five: timer B ch0..3, comparator A, comparator B, timer 0, timer 1
  // Bank six: timer 2, ADC A, ADC B, ADC zero cross, PWM reload, PWM fault
  assign prio_all = {st_reg.prio6[11:0], st_reg.prio5};

  // Address decode shared by read and write paths
  always_comb begin
    case (reg_idx)
      IDX_PRIO5, IDX_PRIO6, IDX_VBA, IDX_FAST_IRQ0_SELECT, IDX_FAST_IRQ0_TARGET_LOW, IDX_FAST_IRQ0_TARGET_HIGH,
      IDX_FIM1, IDX_FIVAL1, IDX_FIVAH1, IDX_EVT_STATUS, IDX_EVT_ENABLE,
      IDX_EVT_CLEAR: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Event register writes go to the event block
  assign evt_en_wr  = wr_take & (reg_idx == IDX_EVT_ENABLE) & avs_byteenable_i[0];
  assign evt_clr_wr = wr_take & (reg_idx == IDX_EVT_CLEAR) & avs_byteenable_i[0];

  ivc_arbiter #(
    .NUM_SRC  (IVC_NUM_SRC),
    .VEC_BASE (VEC_BASE)
  ) u_arbiter (
    .src_req_i   (src_req_i),
    .prio_all_i  (prio_all),
    .fast0_vec_i (st_reg.fast_irq0_select),
    .fast1_vec_i (st_reg.fim1),
    .win_o       (win)
  );

  // Events seen by software: new request edge, fast vectors issued, core ack
  always_comb begin
    evt                = '0;
    evt[EVT_REQ_RAISE] = win.hit & ~st_reg.core.req;
    evt[EVT_FAST0]     = win.hit & (win.kind == IVC_KIND_FAST0) & ~(st_reg.core.req &
                         (st_reg.core.kind == IVC_KIND_FAST0));
    evt[EVT_FAST1]     = win.hit & (win.kind == IVC_KIND_FAST1) & ~(st_reg.core.req &
                         (st_reg.core.kind == IVC_KIND_FAST1));
    evt[EVT_CORE_ACK]  = core_ack_i & st_reg.core.req;
  end

  ivc_events u_events (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .evt_i      (evt),
    .en_wr_i    (evt_en_wr),
    .clr_wr_i   (evt_clr_wr),
    .wdata_i    (wval[IVC_NUM_EVT-1:0]),
    .status_o   (evt_status),
    .enable_o   (evt_enable),
    .irq_o      (irq_o)
  );

  // Next state: bus handshake, register writes, read capture and core request
  always_comb begin
    st_next     = st_reg;
    // Ack rises one cycle after the request and drops the cycle after it is taken
    st_next.ack = bus_req & ~st_reg.ack;

    // Read data is captured during the wait cycle so it stands when waitrequest falls
    if (bus_req && !st_reg.ack) begin
      st_next.rdata = 32'h0000_0000;
      st_next.resp  = mapped ? RESP_OKAY : RESP_SLVERR;
      if (avs_read_i) begin
        case (reg_idx)
          IDX_PRIO5:      st_next.rdata[15:0] = st_reg.prio5;
          IDX_PRIO6:      st_next.rdata[15:0] = st_reg.prio6;
          IDX_VBA:        st_next.rdata[15:0] = st_reg.vector_base_address;
          IDX_FAST_IRQ0_SELECT:       st_next.rdata[IVC_VEC_W-1:0] = st_reg.fast_irq0_select;
          IDX_FAST_IRQ0_TARGET_LOW:     st_next.rdata[15:0] = st_reg.fast_irq0_target_low;
          IDX_FAST_IRQ0_TARGET_HIGH:     st_next.rdata[IVC_FHI_W-1:0] = st_reg.fast_irq0_target_high;
          IDX_FIM1:       st_next.rdata[IVC_VEC_W-1:0] = st_reg.fim1;
          IDX_FIVAL1:     st_next.rdata[15:0] = st_reg.fival1;
          IDX_FIVAH1:     st_next.rdata[IVC_FHI_W-1:0] = st_reg.fivah1;
          IDX_EVT_STATUS: st_next.rdata[IVC_NUM_EVT-1:0] = evt_status;
          IDX_EVT_ENABLE: st_next.rdata[IVC_NUM_EVT-1:0] = evt_enable;
          default:        st_next.rdata = 32'h0000_0000; // Clear register is write-only
        endcase
      end
    end

    // Writes land on the edge where waitrequest is low
    if (wr_take) begin
      case (reg_idx)
        IDX_PRIO5: begin
          st_next.prio5 = merge16(st_reg.prio5, wval, wmask, MASK_PRIO5);
        end
        IDX_PRIO6: begin
          // Reserved top nibble is not stored even if software breaks the
          st_next.prio6 = merge16(st_reg.prio6, wval, wmask, MASK_PRIO6);
        end
        IDX_VBA: begin
          st_next.vector_base_address = merge16(st_reg.vector_base_address, wval, wmask, MASK_VBA);
        end
        IDX_FAST_IRQ0_SELECT: begin
          st_next.fast_irq0_select = IVC_VEC_W'(merge16({10'h000, st_reg.fast_irq0_select}, wval, wmask, MASK_FIM));
        end
        IDX_FAST_IRQ0_TARGET_LOW: begin
          st_next.fast_irq0_target_low = merge16(st_reg.fast_irq0_target_low, wval, wmask, 16'hffff);
        end
        IDX_FAST_IRQ0_TARGET_HIGH: begin
          st_next.fast_irq0_target_high = IVC_FHI_W'(merge16({11'h000, st_reg.fast_irq0_target_high}, wval, wmask, MASK_FIVAH));
        end
        IDX_FIM1: begin
          st_next.fim1 = IVC_VEC_W'(merge16({10'h000, st_reg.fim1}, wval, wmask, MASK_FIM));
        end
        IDX_FIVAL1: begin
          st_next.fival1 = merge16(st_reg.fival1, wval, wmask, 16'hffff);
        end
        IDX_FIVAH1: begin
          st_next.fivah1 = IVC_FHI_W'(merge16({11'h000, st_reg.fivah1}, wval, wmask, MASK_FIVAH));
        end
        default: begin
          // Event registers are handled by the event block; others ignore writes
        end
      endcase
    end

    // Core request follows the arbiter one cycle later; level is field minus one
    st_next.core.req  = win.hit;
    st_next.core.kind = win.kind;
    st_next.core.level = win.hit ? 2'(win.prio - 2'h1) : 2'h0;
    case (win.kind)
      IVC_KIND_FAST0: begin
        // Fast vector bypasses the jump table entirely
        st_next.core.vector_addr = {st_reg.fast_irq0_target_high, st_reg.fast_irq0_target_low};
      end
      IVC_KIND_FAST1: begin
        st_next.core.vector_addr = {st_reg.fivah1, st_reg.fival1};
      end
      default: begin
        st_next.core.vector_addr = table_addr(st_reg.vector_base_address, win.vec);
      end
    endcase
    if (!win.hit) begin
      // Idle address points at the base so the bus never floats to stale values
      st_next.core.vector_addr = table_addr(st_reg.vector_base_address, '0);
    end
  end

  // Single state register; the variant strap is a parameter, never a port
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st_reg          <= '0;
      st_reg.prio5    <= RST_PRIO;
      st_reg.prio6    <= RST_PRIO;
      st_reg.vector_base_address      <= VBA_RESET & MASK_VBA;
      st_reg.fast_irq0_target_low   <= RST_ZERO;
      st_reg.fival1   <= RST_ZERO;
      st_reg.core.kind <= IVC_KIND_TABLE;
      st_reg.core.vector_addr <= table_addr(VBA_RESET, '0);
    end else begin
      st_reg <= st_next;
    end
  end

  assign core_req_o = st_reg.core;

endmodule

/* File: verilog/ivc_pkg.sv */
// Constants, register map and carrier types of the interrupt priority and vector block
package ivc_pkg;
  localparam int          IVC_NUM_SRC      = 14;
  localparam int          IVC_PRIO_W       = 2;
  localparam int          IVC_VEC_W        = 6;
  localparam int          IVC_ADDR_W       = 21;
  localparam int          IVC_BASE_W       = 14;
  localparam int          IVC_OFS_W        = 7;
  localparam int          IVC_FHI_W        = 5;
  localparam int          IVC_NUM_EVT      = 4;
  // Register indices; byte address is four times the index
  localparam logic [5:0]  IDX_PRIO5        = 6'h05;
  localparam logic [5:0]  IDX_PRIO6        = 6'h06;
  localparam logic [5:0]  IDX_VBA          = 6'h07;
  localparam logic [5:0]  IDX_FAST_IRQ0_SELECT         = 6'h08;
  localparam logic [5:0]  IDX_FAST_IRQ0_TARGET_LOW       = 6'h09;
  localparam logic [5:0]  IDX_FAST_IRQ0_TARGET_HIGH       = 6'h0a;
  localparam logic [5:0]  IDX_FIM1         = 6'h0b;
  localparam logic [5:0]  IDX_FIVAL1       = 6'h0c;
  localparam logic [5:0]  IDX_FIVAH1       = 6'h0d;
  localparam logic [5:0]  IDX_EVT_STATUS   = 6'h10;
  localparam logic [5:0]  IDX_EVT_ENABLE   = 6'h11;
  localparam logic [5:0]  IDX_EVT_CLEAR    = 6'h12;
  // Writable masks; reserved bits are stored as zero and read as zero
  localparam logic [15:0] MASK_PRIO5       = 16'hffff;
  localparam logic [15:0] MASK_PRIO6       = 16'h0fff;
  localparam logic [15:0] MASK_VBA         = 16'h3fff;
  localparam logic [15:0] MASK_FIM         = 16'h003f;
  localparam logic [15:0] MASK_FIVAH       = 16'h001f;
  localparam logic [15:0] RST_PRIO         = 16'h0000;
  localparam logic [15:0] RST_ZERO         = 16'h0000;
  localparam logic [1:0]  PRIO_MASKED      = 2'h0;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
  // Event bit positions
  localparam int          EVT_REQ_RAISE    = 0;
  localparam int          EVT_FAST0        = 1;
  localparam int          EVT_FAST1        = 2;
  localparam int          EVT_CORE_ACK     = 3;

  typedef enum logic [1:0] {
    IVC_KIND_TABLE,
    IVC_KIND_FAST0,
    IVC_KIND_FAST1
  } ivc_kind_t;

  // What the core sees
  typedef struct packed {
    logic                  req;
    logic [1:0]            level;
    ivc_kind_t             kind;
    logic [IVC_ADDR_W-1:0] vector_addr;
  } ivc_core_req_t;

  // Arbiter verdict
  typedef struct packed {
    logic                 hit;
    logic [1:0]           prio;
    logic [IVC_VEC_W-1:0] vec;
    ivc_kind_t            kind;
  } ivc_win_t;

  typedef struct packed {
    logic [IVC_NUM_EVT-1:0] status;
    logic [IVC_NUM_EVT-1:0] enable;
  } ivc_evt_state_t;
endpackage

/* File: verilog/ivc_arbiter.sv */
// Combinational pick of the winning source among enabled requests
`timescale 1ns/1ps
module ivc_arbiter import ivc_pkg::*; #(
  parameter int                   NUM_SRC  = IVC_NUM_SRC,
  parameter logic [IVC_VEC_W-1:0] VEC_BASE = 6'h10
) (
  input  wire logic [NUM_SRC-1:0]           src_req_i,
  input  wire logic [2*NUM_SRC-1:0]         prio_all_i,
  input  wire logic [IVC_VEC_W-1:0]         fast0_vec_i,
  input  wire logic [IVC_VEC_W-1:0]         fast1_vec_i,
  output      ivc_win_t                     win_o
);
  // Score is {fast0, fast1, priority}; strict compare keeps the lowest vector on ties
  always_comb begin
    logic [3:0]           best;
    logic [3:0]           score;
    logic [IVC_VEC_W-1:0] vec;
    best  = 4'h0;
    score = 4'h0;
    vec   = '0;
    win_o = '{hit: 1'b0, prio: PRIO_MASKED, vec: '0, kind: IVC_KIND_TABLE};
    for (int i = 0; i < NUM_SRC; i++) begin
      vec   = VEC_BASE + IVC_VEC_W'(i);
      score = {vec == fast0_vec_i, vec == fast1_vec_i, prio_all_i[2*i +: 2]};
      // Masked field never requests, so level 3 cannot arise here
      if (src_req_i[i] && prio_all_i[2*i +: 2] != PRIO_MASKED && score > best) begin
        best       = score;
        win_o.hit  = 1'b1;
        win_o.prio = prio_all_i[2*i +: 2];
        win_o.vec  = vec;
        win_o.kind = score[3] ? IVC_KIND_FAST0 : (score[2] ? IVC_KIND_FAST1 : IVC_KIND_TABLE);
      end
    end
  end
endmodule

/* File: verilog/ivc_events.sv */
// Sticky event status, enable mask and level interrupt output
`timescale 1ns/1ps
module ivc_events import ivc_pkg::*; (
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic [IVC_NUM_EVT-1:0] evt_i,
  input  wire logic                   en_wr_i,
  input  wire logic                   clr_wr_i,
  input  wire logic [IVC_NUM_EVT-1:0] wdata_i,
  output      logic [IVC_NUM_EVT-1:0] status_o,
  output      logic [IVC_NUM_EVT-1:0] enable_o,
  output      logic                   irq_o
);
  ivc_evt_state_t st_reg;
  ivc_evt_state_t st_next;

  // A new event beats a clear in the same cycle so nothing is lost
  always_comb begin
    st_next = st_reg;
    if (clr_wr_i) begin
      st_next.status = st_reg.status & ~wdata_i;
    end
    st_next.status = st_next.status | evt_i;
    if (en_wr_i) begin
      st_next.enable = wdata_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign status_o = st_reg.status;
  assign enable_o = st_reg.enable;
  assign irq_o    = |(st_reg.status & st_reg.enable);
endmodule

/* File: verif/ivc_ctrl_chk.sv */
// Port-level assertions for the interrupt priority and vector block
`timescale 1ns/1ps
module ivc_ctrl_chk import ivc_pkg::*; #(
  parameter logic [15:0]          VBA_RESET = 16'h0000,
  parameter logic [IVC_VEC_W-1:0] VEC_BASE  = 6'h10
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic [7:0]             avs_address_i,
  input  wire logic                   avs_read_i,
  input  wire logic                   avs_write_i,
  input  wire logic [31:0]            avs_readdata_o,
  input  wire logic [1:0]             avs_response_o,
  input  wire logic                   avs_waitrequest_o,
  input  wire logic [IVC_NUM_SRC-1:0] src_req_i,
  input  wire ivc_core_req_t          core_req_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic bus_req;
  logic mapped;
  // Decode kept here so the checker does not lean on the design's own decoder
  assign bus_req = avs_read_i | avs_write_i;
  assign mapped  = avs_address_i[7:2] inside {IDX_PRIO5, IDX_PRIO6, IDX_VBA, IDX_FAST_IRQ0_SELECT, IDX_FAST_IRQ0_TARGET_LOW, IDX_FAST_IRQ0_TARGET_HIGH,
                                              IDX_FIM1, IDX_FIVAL1, IDX_FIVAH1, IDX_EVT_STATUS, IDX_EVT_ENABLE,
                                              IDX_EVT_CLEAR};
  // A bus access is taken with one wait state, then answered
  sequence s_take;
    bus_req && avs_waitrequest_o;
  endsequence
  sequence s_answer;
    bus_req && !avs_waitrequest_o;
  endsequence
  a_one_wait_state: assert property ($rose(bus_req) |-> s_take ##1 s_answer)
    else $error("bus access not answered after exactly one wait state");
  a_idle_no_wait: assert property (!bus_req |-> !avs_waitrequest_o)
    else $error("waitrequest high with no access");
  a_unmapped_error: assert property (avs_read_i && !avs_waitrequest_o && !mapped
                                     |-> avs_response_o == RESP_SLVERR && avs_readdata_o == 32'h0)
    else $error("unmapped read not refused");
  a_mapped_okay: assert property (avs_read_i && !avs_waitrequest_o && mapped
                                  |-> avs_response_o == RESP_OKAY && avs_readdata_o[31:16] == 16'h0)
    else $error("mapped read answered badly");
  a_level_below_three: assert property (core_req_o.req |-> core_req_o.level != 2'h3)
    else $error("request presented at level three");
  a_quiet_no_req: assert property (src_req_i == '0 |=> !core_req_o.req)
    else $error("request presented with no source active");
  a_table_offset: assert property (core_req_o.req && core_req_o.kind == IVC_KIND_TABLE
                                   |-> core_req_o.vector_addr[0] == 1'b0
                                       && (core_req_o.vector_addr[6:1] - VEC_BASE) < 6'(IVC_NUM_SRC))
    else $error("table vector offset outside the source range");
  a_vba_at_reset: assert property ($rose(rst_n_i) |-> core_req_o.vector_addr == {VBA_RESET[13:0], 7'h00})
    else $error("vector address after reset differs from base reset value");
endmodule

bind ivc_ctrl ivc_ctrl_chk #(.VBA_RESET(VBA_RESET), .VEC_BASE(VEC_BASE)) i_ivc_ctrl_chk (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o), .avs_response_o(avs_response_o),
  .avs_waitrequest_o(avs_waitrequest_o), .src_req_i(src_req_i), .core_req_o(core_req_o));

/* File: verif/ivc_core_model.sv */
// Behavioural processor core that takes presented vectors
`timescale 1ns/1ps
module ivc_core_model import ivc_pkg::*; (
  input  wire logic          core_clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          slow_i,
  input  wire ivc_core_req_t core_req_i,
  output      logic          core_ack_o
);
  logic [1:0] wait_cnt;
  // Acknowledge at once, or after a few cycles when slow; one-cycle pulse
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wait_cnt   <= 2'h0;
      core_ack_o <= 1'b0;
    end else if (core_req_i.req && !core_ack_o) begin
      wait_cnt   <= wait_cnt + 2'h1;
      core_ack_o <= !slow_i || (wait_cnt == 2'h3);
    end else begin
      wait_cnt   <= 2'h0;
      core_ack_o <= 1'b0;
    end
  end
endmodule

/* File: verif/tb_irq_priority_vector_ctrl.sv */
// Register-level tests of the interrupt priority and vector block
`timescale 1ns/1ps
module tb_irq_priority_vector_ctrl;
  import ivc_pkg::*;
  localparam logic [15:0] VBA_RST = 16'h0000;
  localparam logic [5:0]  VBASE   = 6'h10;
  logic                   core_clk_i;
  logic                   rst_n_i;
  logic [7:0]             avs_address_i;
  logic                   avs_read_i;
  logic                   avs_write_i;
  logic [31:0]            avs_writedata_i;
  logic [31:0]            avs_readdata_o;
  logic [1:0]             avs_response_o;
  logic                   avs_waitrequest_o;
  logic [IVC_NUM_SRC-1:0] src_req_i;
  logic                   core_ack_i;
  logic                   slow;
  ivc_core_req_t          core_req_o;
  logic                   irq_o;
  int                     fails = 0;
  int                     tests_run = 0;

  ivc_ctrl #(.VBA_RESET(VBA_RST), .VEC_BASE(VBASE)) i_ivc_ctrl (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'h3),
    .avs_readdata_o(avs_readdata_o), .avs_response_o(avs_response_o), .avs_waitrequest_o(avs_waitrequest_o),
    .src_req_i(src_req_i), .core_ack_i(core_ack_i), .core_req_o(core_req_o), .irq_o(irq_o));
  ivc_core_model i_ivc_core_model (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .slow_i(slow), .core_req_i(core_req_o), .core_ack_o(core_ack_i));

  // 40 MHz clock
  initial begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_core(input ivc_core_req_t got, input ivc_core_req_t exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Entered just after a rising edge; holds the request until waitrequest is seen low
  task automatic bus_xfer(input logic wr, input logic [5:0] idx, input logic [15:0] wd,
                          output logic [31:0] rd, output logic [1:0] rsp);
    int n;
    n = 0;
    avs_address_i   <= {idx, 2'b00};
    avs_write_i     <= wr;
    avs_read_i      <= ~wr;
    avs_writedata_i <= {16'h0000, wd};
    // Waitrequest and read data are taken at the rising edge, before that edge updates them
    @(posedge core_clk_i);
    while (avs_waitrequest_o !== 1'b0 && n < 40) begin
      @(posedge core_clk_i);
      n++;
    end
    if (n == 40) fails++;
    rd  = avs_readdata_o;
    rsp = avs_response_o;
    avs_read_i  <= 1'b0;
    avs_write_i <= 1'b0;
    // Let one edge pass so the next call never re-raises a strobe in the same step
    @(posedge core_clk_i);
  endtask
  task automatic bus_wr(input logic [5:0] idx, input logic [15:0] wd);
    logic [31:0] rd;
    logic [1:0]  rsp;
    bus_xfer(1'b1, idx, wd, rd, rsp);
  endtask
  // Request lines change at an edge; the answer is looked at after the next edge
  task automatic set_src(input logic [IVC_NUM_SRC-1:0] v);
    src_req_i <= v;
    @(negedge core_clk_i);
    @(negedge core_clk_i);
    @(posedge core_clk_i);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog: the whole run needs well under this many cycles
  initial begin : watchdog
    int cyc;
    cyc = 0;
    while (cyc < 6000) begin
      @(posedge core_clk_i);
      cyc++;
    end
    fails++;
    $display("watchdog expired");
    tally_and_finish();
  end

  initial begin : main
    logic [31:0]   rd;
    logic [1:0]    rsp;
    logic [5:0]    idx;
    logic [15:0]   rmask [4];
    logic [5:0]    ridx [4];
    ivc_core_req_t exp;
    int            i;
    int            f;
    rst_n_i = 1'b0;
    avs_address_i = 8'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    src_req_i = '0;
    slow = 1'b0;
    ridx  = '{IDX_PRIO5, IDX_PRIO6, IDX_VBA, IDX_FAST_IRQ0_SELECT};
    rmask = '{16'hffff, 16'h0fff, 16'h3fff, 16'h003f};
    repeat (16) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    // Reset values, then reserved bits written as ones read back as zero
    for (i = 0; i < 4; i++) begin
      bus_xfer(1'b0, ridx[i], 16'h0000, rd, rsp);
      cmp_val(rd, (ridx[i] == IDX_VBA) ? {16'h0, VBA_RST} : 32'h0);
      bus_wr(ridx[i], 16'hffff);
      bus_xfer(1'b0, ridx[i], 16'h0000, rd, rsp);
      cmp_val(rd, {16'h0, rmask[i]});
      bus_wr(ridx[i], 16'h0000);
    end
    $display("test reset_and_reserved done");
    // Every field of both banks at every code; bank five holds sources 0..7, bank six 8..13
    bus_wr(IDX_VBA, 16'h2a5c);
    for (i = 0; i < IVC_NUM_SRC; i++) begin
      for (f = 0; f < 4; f++) begin
        idx = (i < 8) ? IDX_PRIO5 : IDX_PRIO6;
        bus_wr(idx, 16'(f) << (2 * (i % 8)));
        set_src(14'h0001 << i);
        if (f == 0) begin
          cmp_val({31'h0, core_req_o.req}, 32'h0);
        end else begin
          exp = '{req: 1'b1, level: 2'(f - 1), kind: IVC_KIND_TABLE,
                  vector_addr: {14'h2a5c, 6'(VBASE + 6'(i)), 1'b0}};
          cmp_core(core_req_o, exp);
        end
        set_src('0);
      end
    end
    $display("test field_scan done");
    // Same level goes to the lowest source; a higher level beats a lower index
    slow = 1'b1;
    bus_wr(IDX_PRIO6, 16'h0000);
    bus_wr(IDX_PRIO5, 16'h1220);
    set_src(14'h0054);
    exp = '{req: 1'b1, level: 2'h1, kind: IVC_KIND_TABLE, vector_addr: {14'h2a5c, 6'(VBASE + 6'h2), 1'b0}};
    cmp_core(core_req_o, exp);
    bus_wr(IDX_PRIO5, 16'h3220);
    // New field reaches the arbiter at the edge the write lands; the core request follows one edge later
    set_src(14'h0054);
    exp = '{req: 1'b1, level: 2'h2, kind: IVC_KIND_TABLE, vector_addr: {14'h2a5c, 6'(VBASE + 6'h6), 1'b0}};
    cmp_core(core_req_o, exp);
    $display("test arbitration done");
    // Fast sources at level two win over a lower-indexed level-two source
    bus_wr(IDX_PRIO5, 16'h3320);
    bus_wr(IDX_PRIO6, 16'h000c);
    bus_wr(IDX_FAST_IRQ0_SELECT, 16'(VBASE + 6'h9));
    bus_wr(IDX_FAST_IRQ0_TARGET_LOW, 16'hbeef);
    bus_wr(IDX_FAST_IRQ0_TARGET_HIGH, 16'h0015);
    bus_wr(IDX_FIM1, 16'(VBASE + 6'h6));
    bus_wr(IDX_FIVAL1, 16'h1357);
    bus_wr(IDX_FIVAH1, 16'h000a);
    set_src(14'h0250);
    exp = '{req: 1'b1, level: 2'h2, kind: IVC_KIND_FAST0, vector_addr: {5'h15, 16'hbeef}};
    cmp_core(core_req_o, exp);
    set_src(14'h0050);
    exp = '{req: 1'b1, level: 2'h2, kind: IVC_KIND_FAST1, vector_addr: {5'h0a, 16'h1357}};
    cmp_core(core_req_o, exp);
    $display("test fast_interrupts done");
    // Sticky event, enable mask, clear, and an unmapped access
    slow = 1'b0;
    set_src('0);
    bus_wr(IDX_EVT_CLEAR, 16'h000f);
    bus_xfer(1'b0, IDX_EVT_STATUS, 16'h0000, rd, rsp);
    cmp_val(rd, 32'h0);
    bus_wr(IDX_EVT_ENABLE, 16'h0001);
    set_src(14'h0040);
    cmp_val({31'h0, irq_o}, 32'h1);
    bus_xfer(1'b0, IDX_EVT_STATUS, 16'h0000, rd, rsp);
    cmp_val(rd & 32'h1, 32'h1);
    bus_wr(IDX_EVT_ENABLE, 16'h0000);
    cmp_val({31'h0, irq_o}, 32'h0);
    bus_wr(IDX_EVT_CLEAR, 16'h0001);
    bus_xfer(1'b0, IDX_EVT_STATUS, 16'h0000, rd, rsp);
    cmp_val(rd & 32'h1, 32'h0);
    bus_xfer(1'b0, 6'h3f, 16'h0000, rd, rsp);
    cmp_val({rsp, rd[29:0]}, {RESP_SLVERR, 30'h0});
    $display("test events_and_unmapped done");
    tally_and_finish();
  end
endmodule
